// [test/gage_far_side.sv]
// Far-side model: isolated control lines and the air shutoff valve.
// Assumes the bench sets wanted line levels; bit order follows the IN_ constants.
module gage_far_side (
   input wire logic clk_i,
   input wire logic [3:0] want_i,
   input wire logic air_off_i,
   output logic [3:0] line_o,
   output logic full_flow_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] pending = 4'h0;
   initial line_o = 4'h0;
   // Wanted levels are taken on the rising edge so falling-edge bench writes never race
   always @(posedge clk_i) begin
      pending <= want_i;
   end
   // Lines move only off the sampling edge, as a slow opto input would
   always @(negedge clk_i) begin
      line_o <= pending;
   end
   // Valve passes full flow unless driven
   assign full_flow_o = !air_off_i;
endmodule

// [test/gage_io_and_air_shutoff_tb_top.sv]
// Bench for the gage I/O and air shutoff block, with a short second tick.
// Assumes the far-side model drives the four isolated control pins.
`define CHECK(act, exp) begin \
   checks_done++; \
   if ((act) !== (exp)) begin \
      failures++; \
      $display("Error at %0t: got %h expected %h", $time, act, exp); \
   end \
end
module gage_io_and_air_shutoff_tb_top import gage_io_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int T = 4;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic run = 1'b0;
   logic cal = 1'b0;
   logic [1:0] sel = 2'h0;
   logic [3:0] bars = 4'h0;
   logic over = 1'b0;
   logic good = 1'b0;
   logic under = 1'b0;
   logic [4:0] cls = 5'h00;
   logic [3:0] want = 4'h0;
   logic [3:0] line;
   logic air_off, flash, shown, present, send, clear, full;
   logic [4:0] relay;
   int failures = 0;
   int checks_done = 0;
   always #50 clk = ~clk;
   gage_far_side far (.clk_i(clk), .want_i(want), .air_off_i(air_off), .line_o(line),
      .full_flow_o(full));
   gage_io_and_air_shutoff #(.TICK_CYCLES(T)) dut (.REF_CLK_I(clk), .NRST_I(nrst),
      .RUN_MODE_I(run), .CAL_MODE_I(cal), .DELAY_SEL_I(sel), .DEVIATION_BARS_I(bars),
      .OVER_I(over), .GOOD_I(good), .UNDER_I(under), .CLASS_I(cls),
      .SHUTOFF_PRESENT_I(line[0]), .FOOTSWITCH_I(line[1]), .RUNOUT_RESET_I(line[2]),
      .CLASS_REQ_I(line[3]), .AIR_OFF_O(air_off), .WAIT_FLASH_O(flash),
      .AIR_OFF_SHOWN_O(shown), .SHUTOFF_PRESENT_O(present), .SEND_DATA_O(send),
      .CLEAR_DETECT_O(clear), .RELAY_O(relay));
   task cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task finish_test;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task t_relays;
      over = 1'b1;
      under = 1'b1;
      cls = 5'h16;
      cyc(4);
      `CHECK(relay, 5'h15)
      want[IN_CLASS_REQ] = 1'b1;
      cyc(4);
      `CHECK(relay, 5'h16)
      want[IN_CLASS_REQ] = 1'b0;
   endtask
   // Pin held high gives one pulse: one cycle for the pin to move, three edges after it
   task t_pulse(input int b);
      int n, first;
      n = 0;
      first = 0;
      want[b] = 1'b1;
      for (int i = 1; i <= 8; i++) begin
         cyc(1);
         if (((b == IN_FOOTSWITCH) ? send : clear) === 1'b1) begin
            n++;
            if (first == 0) first = i;
         end
      end
      `CHECK(n, 1)
      `CHECK(first, 4)
      want[b] = 1'b0;
      cyc(2);
   endtask
   task t_present;
      want[IN_PRESENT] = 1'b0;
      cyc(4);
      `CHECK(present, 1'b0)
      want[IN_PRESENT] = 1'b1;
      cyc(4);
      `CHECK(present, 1'b1)
   endtask
   // Reset in mid-run must reopen the valve and drop both indications and the relays at once
   task t_reset_mid;
      int n;
      n = 0;
      sel = DELAY_SEL_SHORT;
      bars = 4'h0;
      run = 1'b1;
      while (air_off !== 1'b1 && n < 70) begin
         cyc(1);
         n++;
      end
      if (air_off !== 1'b1) begin
         failures++;
         finish_test();
      end
      `CHECK(n, int'(DELAY_SHORT_S) * T + 1)
      nrst = 1'b0;
      cyc(1);
      `CHECK({air_off, flash, shown, relay}, 8'h00)
      run = 1'b0;
      nrst = 1'b1;
      cyc(4);
      `CHECK({air_off, present}, 2'h1)
   endtask
   task t_shutoff(input logic [1:0] s, input int d);
      int n;
      n = 0;
      sel = s;
      bars = 4'h0;
      run = 1'b1;
      while (air_off !== 1'b1 && n < 70) begin
         cyc(1);
         n++;
      end
      if (air_off !== 1'b1) begin
         failures++;
         finish_test();
      end
      `CHECK(n, d * T + 1)
      `CHECK({flash, full}, 2'h2)
      cyc(T);
      `CHECK(flash, 1'b0)
      cyc(2 * T);
      `CHECK({flash, shown}, 2'h1)
      bars = 4'h2;
      cyc(1);
      `CHECK({air_off, shown, full}, 3'h1)
      run = 1'b0;
      bars = 4'h0;
      cyc(2);
   endtask
   // Long enough to pass the longest delay
   task t_blocked(input logic r, input logic c, input logic [1:0] s);
      run = r;
      cal = c;
      sel = s;
      cyc(20 * T);
      `CHECK(air_off, 1'b0)
      run = 1'b0;
      cal = 1'b0;
      cyc(2);
   endtask
   initial begin
      cyc(5);
      `CHECK({air_off, flash, shown, present, send, clear, relay}, 11'h000)
      cyc(5);
      nrst = 1'b1;
      cyc(2);
      t_relays();
      t_pulse(IN_FOOTSWITCH);
      t_pulse(IN_RESET);
      t_present();
      t_shutoff(DELAY_SEL_SHORT, int'(DELAY_SHORT_S));
      t_shutoff(DELAY_SEL_MID, int'(DELAY_MID_S));
      t_shutoff(DELAY_SEL_LONG, int'(DELAY_LONG_S));
      t_blocked(1'b1, 1'b1, DELAY_SEL_SHORT);
      t_blocked(1'b0, 1'b0, DELAY_SEL_SHORT);
      t_blocked(1'b1, 1'b0, DELAY_SEL_DISABLED);
      t_reset_mid();
      // Run mode with the assembly unplugged
      want[IN_PRESENT] = 1'b0;
      t_blocked(1'b1, 1'b0, DELAY_SEL_SHORT);
      finish_test();
   end
endmodule

// [verilog/ctrl_input_sync.sv]
// Two-stage synchroniser with rising-edge detect for isolated control lines.
// Assumes the lines are asynchronous levels, high while activated.
module ctrl_input_sync
   import gage_io_pkg::*;
#(
   parameter int WIDTH = IN_COUNT
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic [WIDTH-1:0] line_i,
   output logic [WIDTH-1:0] level_o,
   output logic [WIDTH-1:0] rise_o
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] sync;
      logic [WIDTH-1:0] prev;
   } sync_state_t;

   sync_state_t r;
   sync_state_t next_r;

   always_comb begin
      next_r = r;
      next_r.meta = line_i;
      next_r.sync = r.meta;
      next_r.prev = r.sync;
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   // Edge detect looks only at the second stage
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         assign level_o[i] = r.sync[i];
         assign rise_o[i] = r.sync[i] & ~r.prev[i];
      end
   endgenerate

endmodule

// [verilog/gage_io_and_air_shutoff.sv]
// Isolated I/O control and automatic air shutoff sequencer of the gage.
// Assumes mode, delay select, deviation and results come from logic on REF_CLK_I;
// the four control lines arrive from isolated pins and are synchronised here.

// Overview of operation
// - Air shutoff acts only in run mode
// - Calibration mode keeps shutoff disabled
// - Delay 5, 10, 15 s or disabled
// - Tool out, delay expires, assert air-off
// - Flash waiting, then steady air-off indication
// - Two-bar deviation releases air-off at once
// - Dedicated air-off output drives the valve
// - Sense whether shutoff assembly is connected
// - Footswitch sends measurement data out serially
// - External reset clears runout and peak
// - Class request selects status or class bits
// - Five outputs: shared 0..2, class 3..4
module gage_io_and_air_shutoff
   import gage_io_pkg::*;
#(
   parameter int TICK_CYCLES = SECOND_CYCLES
) (
   input wire logic REF_CLK_I,
   input wire logic NRST_I,
   input wire logic RUN_MODE_I,
   input wire logic CAL_MODE_I,
   input wire logic [1:0] DELAY_SEL_I,
   input wire logic [3:0] DEVIATION_BARS_I,
   input wire logic OVER_I,
   input wire logic GOOD_I,
   input wire logic UNDER_I,
   input wire logic [RELAY_COUNT-1:0] CLASS_I,
   input wire logic SHUTOFF_PRESENT_I,
   input wire logic FOOTSWITCH_I,
   input wire logic RUNOUT_RESET_I,
   input wire logic CLASS_REQ_I,
   output logic AIR_OFF_O,
   output logic WAIT_FLASH_O,
   output logic AIR_OFF_SHOWN_O,
   output logic SHUTOFF_PRESENT_O,
   output logic SEND_DATA_O,
   output logic CLEAR_DETECT_O,
   output logic [RELAY_COUNT-1:0] RELAY_O
);

   typedef struct packed {
      air_state_t st;
      logic [TICK_WIDTH-1:0] tick_cnt;
      logic [3:0] sec_cnt;
      logic air_off;
      logic wait_flash;
      logic air_off_shown;
      logic present;
      logic send_data;
      logic clear_detect;
      logic [RELAY_COUNT-1:0] relay;
   } ctrl_state_t;

   localparam logic [TICK_WIDTH-1:0] TICK_LAST = TICK_WIDTH'(TICK_CYCLES - 1);

   ctrl_state_t r;
   ctrl_state_t next_r;
   logic [IN_COUNT-1:0] in_level;
   logic [IN_COUNT-1:0] in_rise;
   logic enable;
   logic in_part;
   logic tick;
   logic cut_now;
   logic [3:0] delay_s;

   ctrl_input_sync #(
      .WIDTH(IN_COUNT)
   ) u_sync (
      .clk_i(REF_CLK_I),
      .nrst_i(NRST_I),
      .line_i({CLASS_REQ_I, RUNOUT_RESET_I, FOOTSWITCH_I, SHUTOFF_PRESENT_I}),
      .level_o(in_level),
      .rise_o(in_rise)
   );

   always_comb begin
      case (DELAY_SEL_I)
         DELAY_SEL_SHORT: delay_s = DELAY_SHORT_S;
         DELAY_SEL_MID: delay_s = DELAY_MID_S;
         DELAY_SEL_LONG: delay_s = DELAY_LONG_S;
         default: delay_s = DELAY_SHORT_S;
      endcase
   end

   // Missing assembly or a non-run mode must never leave the valve closed
   assign enable = RUN_MODE_I && !CAL_MODE_I && (DELAY_SEL_I != DELAY_SEL_DISABLED)
      && in_level[IN_PRESENT];
   assign in_part = DEVIATION_BARS_I >= RESTORE_BARS;
   assign tick = r.tick_cnt == TICK_LAST;
   assign cut_now = (r.st == S_ARMED) && !in_part && tick && (r.sec_cnt == delay_s - 4'h1);

   always_comb begin
      next_r = r;
      next_r.present = in_level[IN_PRESENT];
      next_r.send_data = in_rise[IN_FOOTSWITCH];
      next_r.clear_detect = in_rise[IN_RESET];
      if (in_level[IN_CLASS_REQ]) begin
         next_r.relay[SHARED_COUNT-1:0] = CLASS_I[SHARED_COUNT-1:0];
      end else begin
         next_r.relay[SHARED_COUNT-1:0] = {UNDER_I, GOOD_I, OVER_I};
      end
      next_r.relay[RELAY_COUNT-1:SHARED_COUNT] = CLASS_I[RELAY_COUNT-1:SHARED_COUNT];
      next_r.tick_cnt = tick ? '0 : r.tick_cnt + TICK_WIDTH'(1);
      case (r.st)
         S_IDLE: begin
            next_r.tick_cnt = '0;
            next_r.sec_cnt = '0;
            if (enable) begin
               next_r.st = S_ARMED;
            end
         end
         S_ARMED: begin
            // Timing restarts every time the tooling sits in a part
            if (in_part) begin
               next_r.tick_cnt = '0;
               next_r.sec_cnt = '0;
            end else if (cut_now) begin
               next_r.st = S_WAIT;
               next_r.air_off = 1'b1;
               next_r.wait_flash = 1'b1;
               next_r.sec_cnt = '0;
            end else if (tick) begin
               next_r.sec_cnt = r.sec_cnt + 4'h1;
            end
         end
         S_WAIT: begin
            if (tick) begin
               next_r.wait_flash = !r.wait_flash;
               next_r.sec_cnt = r.sec_cnt + 4'h1;
               if (r.sec_cnt == WAIT_SHOW_S - 4'h1) begin
                  next_r.st = S_OFF;
                  next_r.wait_flash = 1'b0;
                  next_r.air_off_shown = 1'b1;
                  next_r.sec_cnt = '0;
               end
            end
         end
         S_OFF: begin
            next_r.tick_cnt = '0;
         end
         default: begin
            next_r.st = S_IDLE;
         end
      endcase
      if ((r.st == S_WAIT || r.st == S_OFF) && in_part) begin
         next_r.st = S_ARMED;
         next_r.air_off = 1'b0;
         next_r.wait_flash = 1'b0;
         next_r.air_off_shown = 1'b0;
         next_r.tick_cnt = '0;
         next_r.sec_cnt = '0;
      end
      if (!enable) begin
         next_r.st = S_IDLE;
         next_r.air_off = 1'b0;
         next_r.wait_flash = 1'b0;
         next_r.air_off_shown = 1'b0;
         next_r.tick_cnt = '0;
         next_r.sec_cnt = '0;
      end
   end

   always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         r <= '0;
         r.st <= S_IDLE;
      end else begin
         r <= next_r;
      end
   end

   assign AIR_OFF_O = r.air_off;
   assign WAIT_FLASH_O = r.wait_flash;
   assign AIR_OFF_SHOWN_O = r.air_off_shown;
   assign SHUTOFF_PRESENT_O = r.present;
   assign SEND_DATA_O = r.send_data;
   assign CLEAR_DETECT_O = r.clear_detect;
   assign RELAY_O = r.relay;

   default clocking cb @(posedge REF_CLK_I);
   endclocking
   default disable iff (!NRST_I);

   run_only_a: assert property (!RUN_MODE_I |=> !AIR_OFF_O)
      else $error("air cut outside run mode");
   cal_hold_a: assert property (CAL_MODE_I |=> !AIR_OFF_O && r.st == S_IDLE)
      else $error("shutoff active in calibration mode");
   delay_off_a: assert property (DELAY_SEL_I == DELAY_SEL_DISABLED |=> !AIR_OFF_O)
      else $error("shutoff active while disabled");
   cut_cause_a: assert property ($rose(AIR_OFF_O) |-> $past(cut_now))
      else $error("air cut without delay expiry");
   wait_show_a: assert property ($rose(AIR_OFF_O) |-> WAIT_FLASH_O && !AIR_OFF_SHOWN_O)
      else $error("waiting indication missing at cut");
   shown_entry_a: assert property ($rose(AIR_OFF_SHOWN_O) |-> AIR_OFF_O && !WAIT_FLASH_O
      && $past(r.st) == S_WAIT)
      else $error("steady indication without waiting phase");
   shown_steady_a: assert property (AIR_OFF_SHOWN_O |-> AIR_OFF_O && !WAIT_FLASH_O)
      else $error("steady indication without air cut");
   restore_air_a: assert property (AIR_OFF_O && in_part |=> !AIR_OFF_O)
      else $error("air not restored on deviation");
   valve_state_a: assert property (AIR_OFF_O |-> r.st == S_WAIT || r.st == S_OFF)
      else $error("air-off in wrong state");
   present_gate_a: assert property (!in_level[IN_PRESENT] |=> !AIR_OFF_O)
      else $error("air cut with no assembly");
   present_follow_a: assert property (1'b1 |=>
      SHUTOFF_PRESENT_O == $past(in_level[IN_PRESENT]))
      else $error("presence output not following pin");
   footswitch_send_a: assert property (in_rise[IN_FOOTSWITCH] |=> SEND_DATA_O
      ##1 !SEND_DATA_O)
      else $error("footswitch send not a single pulse");
   reset_clear_a: assert property (in_rise[IN_RESET] |=> CLEAR_DETECT_O)
      else $error("detector clear missing");
   clear_pulse_a: assert property (CLEAR_DETECT_O |=> !CLEAR_DETECT_O)
      else $error("detector clear longer than one cycle");
   class_sel_a: assert property (in_level[IN_CLASS_REQ] |=>
      RELAY_O[SHARED_COUNT-1:0] == $past(CLASS_I[SHARED_COUNT-1:0]))
      else $error("shared outputs not carrying class");
   class_status_a: assert property (!in_level[IN_CLASS_REQ] |=>
      RELAY_O[SHARED_COUNT-1:0] == {$past(UNDER_I), $past(GOOD_I), $past(OVER_I)})
      else $error("shared outputs not carrying results");
   class_high_a: assert property (1'b1 |=>
      RELAY_O[RELAY_COUNT-1:SHARED_COUNT] == $past(CLASS_I[RELAY_COUNT-1:SHARED_COUNT]))
      else $error("class bits 3 and 4 wrong");
   idle_quiet_a: assert property (r.st == S_IDLE |->
      !AIR_OFF_O && !WAIT_FLASH_O && !AIR_OFF_SHOWN_O)
      else $error("indication or cut while idle");

endmodule

// [verilog/gage_io_pkg.sv]
// Constants and types shared by the gage I/O and air shutoff logic.
// Assumes a single 10 MHz reference clock and an active-low asynchronous reset.
package gage_io_pkg;

   localparam int CLK_PERIOD_NS = 100;
   localparam int SECOND_NS = 1_000_000_000;
   // Cycles in one second, rounded down
   localparam int SECOND_CYCLES = SECOND_NS / CLK_PERIOD_NS;
   localparam int TICK_WIDTH = 24;

   // Idle delay selection codes
   localparam logic [1:0] DELAY_SEL_DISABLED = 2'h0;
   localparam logic [1:0] DELAY_SEL_SHORT = 2'h1;
   localparam logic [1:0] DELAY_SEL_MID = 2'h2;
   localparam logic [1:0] DELAY_SEL_LONG = 2'h3;

   // Idle delays and waiting indication length, in seconds
   localparam logic [3:0] DELAY_SHORT_S = 4'h5;
   localparam logic [3:0] DELAY_MID_S = 4'hA;
   localparam logic [3:0] DELAY_LONG_S = 4'hF;
   localparam logic [3:0] WAIT_SHOW_S = 4'h3;

   // Deviation in light bars that means the tooling sits in a part
   localparam logic [3:0] RESTORE_BARS = 4'h2;

   // Bit positions of the synchronised control inputs
   localparam int IN_PRESENT = 0;
   localparam int IN_FOOTSWITCH = 1;
   localparam int IN_RESET = 2;
   localparam int IN_CLASS_REQ = 3;
   localparam int IN_COUNT = 4;

   localparam int RELAY_COUNT = 5;
   localparam int SHARED_COUNT = 3;

   typedef enum logic [1:0] {
      S_IDLE,
      S_ARMED,
      S_WAIT,
      S_OFF
   } air_state_t;

endpackage
